// file: radio_coexistence_signaling_tb.sv
// bench for rcs_coex; assumes rcs_peer on the peer pin and rcs_chk bound in
`timescale 1ns/100ps
`default_nettype none
module radio_coexistence_signaling_tb;
  logic               clk = 1'b0, rst_n = 1'b0, pa, tm, ma, pk, ln;
  rcs_pkg::rcs_time_t tb = '0;
  int                 fail_count = 0, n_compared = 0, cyc = 0;
  localparam int      TM = 0, MA = 1, PK = 2, LN = 3;
  initial forever #5 clk = ~clk;
  rcs_coex #(.PPS_CYC(200)) uut (.clk(clk), .rst_n(rst_n), .tb(tb), .peer_active_in(pa),
    .time_mark_out(tm), .modem_active_out(ma), .peer_active(pk), .lna_enable(ln));
  rcs_peer peer (.modem_active_out(ma), .peer_active_in(pa));
  task automatic results;
    $display("compared %0d failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results
  task automatic chk(input int n, input int sel, input logic exp);
    logic got;
    repeat (n) @(posedge clk);
    #1 got = (sel == TM) ? tm : (sel == MA) ? ma : (sel == PK) ? pk : ln;
    n_compared++;
    fail_count += int'(got !== exp);
    if (got !== exp) $display("unexpected at %0t: got %b", $time, got);
  endtask : chk
  task automatic tick(input logic net);
    @(posedge clk) {tb.net_tick, tb.pos_tick} <= {net, !net};
    @(posedge clk) {tb.net_tick, tb.pos_tick} <= 2'h0;
  endtask : tick
  task automatic t_net;
    tick(1'b1);
    chk(0, TM, 1'b1);
    chk(100, TM, 1'b0);
    tick(1'b0);
    chk(0, TM, 1'b0);
  endtask : t_net
  task automatic t_peer;
    @(posedge clk) tb.trx_on <= 1'b1;
    chk(1, MA, 1'b1);
    chk(5, PK, 1'b0);
    @(posedge clk) tb.trx_on <= 1'b0;
    chk(1, MA, 1'b0);
    chk(5, PK, 1'b1);
    chk(0, LN, 1'b0);
  endtask : t_peer
  task automatic t_pos;
    @(posedge clk) tb.pos_in_use <= 1'b1;
    chk(5, LN, 1'b1);
    chk(0, PK, 1'b0);
    tick(1'b0);
    chk(0, TM, 1'b1);
    chk(120, TM, 1'b0);
    tick(1'b1);
    chk(0, TM, 1'b0);
    chk(100, TM, 1'b1);
  endtask : t_pos
  always @(posedge clk) if (++cyc == 3000) fail_count++;
  always @(posedge clk) if (cyc > 3000) results;
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_net;
    t_peer;
    t_pos;
    results;
  end
endmodule : radio_coexistence_signaling_tb
`default_nettype wire

// file: rcs_coex.sv
// rcs_coex: three-pin coexistence signalling towards a companion radio
// assumes tick inputs are one-cycle pulses from the modem time base
// assumes the peer pin may change at any time relative to clk
// assumes one clock and no software-visible registers
//
// Contract
// - three coexistence pins, one in, two out
// - peer pin doubles as amplifier enable
// - time mark pulse locked to network time
// - positioning use gives once-per-second mark
// - modem_active_out follows own transceiver state
// - modem_active_out low grants peer air time
`timescale 1ns/100ps
`default_nettype none
module rcs_coex #(
  parameter int unsigned PPS_CYC = rcs_pkg::PPS_PERIOD_CYC
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire rcs_pkg::rcs_time_t tb,
  input  wire logic              peer_active_in,
  output logic                   time_mark_out,
  output logic                   modem_active_out,
  output logic                   peer_active,
  output logic                   lna_enable
);

  // ==========================================
  // derived counts
  // cut to the counter widths once, rather than at every compare
  localparam logic [31:0] PPS_LAST    = 32'(PPS_CYC - 1);
  localparam logic [15:0] MARK_RELOAD = 16'(rcs_pkg::MARK_WIDTH_CYC - 1);

  // ==========================================
  // carrier unpack
  logic net_tick;
  logic pos_tick;
  logic pos_in_use;
  logic trx_on;

  assign net_tick   = tb.net_tick;
  assign pos_tick   = tb.pos_tick;
  assign pos_in_use = tb.pos_in_use;
  assign trx_on     = tb.trx_on;

  // ==========================================
  // mode decode
  // positioning use re-purposes the peer pin and swaps the mark source
  function automatic rcs_pkg::rcs_src_t mark_source(input logic in_use);
    rcs_pkg::rcs_src_t sel;
    if (in_use) begin
      sel = rcs_pkg::RCS_SRC_POS;
    end else begin
      sel = rcs_pkg::RCS_SRC_NETWORK;
    end
    return sel;
  endfunction : mark_source

  // one compare shared by both halves of the peer pin split
  function automatic logic is_pos(input rcs_pkg::rcs_src_t sel);
    return sel == rcs_pkg::RCS_SRC_POS;
  endfunction : is_pos

  rcs_pkg::rcs_src_t src;

  assign src = mark_source(pos_in_use);

  // ==========================================
  // input synchroniser
  // the peer pin is asynchronous to clk, so only the synchroniser reads it
  logic peer_sync;

  rcs_sync u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (peer_active_in),
    .q     (peer_sync)
  );

  // ==========================================
  // peer activity
  // pin only means peer activity while positioning is idle
  logic next_peer_active;
  logic next_lna_enable;

  assign next_peer_active = peer_sync & ~is_pos(src);
  assign next_lna_enable  = peer_sync & is_pos(src);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      peer_active <= rcs_pkg::RESET_LEVEL;
    end else begin
      peer_active <= next_peer_active;
    end
  end

  // ==========================================
  // amplifier enable
  // same pin, read as an active-high amplifier enable during positioning
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lna_enable <= rcs_pkg::RESET_LEVEL;
    end else begin
      lna_enable <= next_lna_enable;
    end
  end

  // ==========================================
  // once-per-second fallback counter
  // free runs so a lost positioning tick still yields a pulse
  logic [31:0] pps_cnt;
  logic [31:0] next_pps_cnt;
  logic        pps_wrap;
  logic        next_pps_tick;
  logic        pps_tick;

  assign pps_wrap      = (pps_cnt == PPS_LAST);
  assign next_pps_tick = pps_wrap & ~pos_tick;

  always_comb begin
    next_pps_cnt = pps_cnt + 32'h1;
    if (pos_tick || pps_wrap) begin
      next_pps_cnt = rcs_pkg::PPS_CNT_RESET;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pps_cnt <= rcs_pkg::PPS_CNT_RESET;
    end else begin
      pps_cnt <= next_pps_cnt;
    end
  end

  // ==========================================
  // fallback tick
  // a real tick in the wrap cycle wins, so the mark never doubles
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pps_tick <= rcs_pkg::RESET_LEVEL;
    end else begin
      pps_tick <= next_pps_tick;
    end
  end

  // ==========================================
  // time mark source select
  // no default: both codes of the one-bit source are legal
  logic net_fire;
  logic pos_fire;
  logic fire;

  assign net_fire = net_tick;
  assign pos_fire = pos_tick | pps_tick;

  always_comb begin
    unique case (src)
      rcs_pkg::RCS_SRC_NETWORK: fire = net_fire;
      rcs_pkg::RCS_SRC_POS:     fire = pos_fire;
    endcase
  end

  // ==========================================
  // time mark pulse stretcher
  // a tick during a pulse restarts the full width instead of being lost
  logic [15:0] mark_cnt;
  logic [15:0] next_mark_cnt;
  logic        mark_busy;

  assign mark_busy = (mark_cnt != rcs_pkg::MARK_CNT_RESET);

  always_comb begin
    next_mark_cnt = mark_cnt;
    if (fire) begin
      next_mark_cnt = MARK_RELOAD;
    end else if (mark_busy) begin
      next_mark_cnt = mark_cnt - 16'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mark_cnt <= rcs_pkg::MARK_CNT_RESET;
    end else begin
      mark_cnt <= next_mark_cnt;
    end
  end

  // ==========================================
  // time mark output
  // high from the tick until the count drains, then low
  logic next_time_mark;

  always_comb begin
    next_time_mark = time_mark_out;
    if (fire) begin
      next_time_mark = 1'h1;
    end else if (!mark_busy) begin
      next_time_mark = 1'h0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      time_mark_out <= rcs_pkg::RESET_LEVEL;
    end else begin
      time_mark_out <= next_time_mark;
    end
  end

  // ==========================================
  // modem active / inverted grant
  // low while the own transceiver is off, which the peer reads as a grant
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      modem_active_out <= rcs_pkg::RESET_LEVEL;
    end else begin
      modem_active_out <= trx_on;
    end
  end

endmodule : rcs_coex
`default_nettype wire

// file: rcs_coex_assertions.sv
// rcs_chk: timing checks on the rcs_coex ports; assumes the bench never re-ticks a network pulse
`timescale 1ns/100ps
`default_nettype none
module rcs_chk (
  input wire logic               clk,
  input wire logic               rst_n,
  input wire rcs_pkg::rcs_time_t tb,
  input wire logic               peer_active_in,
  input wire logic               time_mark_out,
  input wire logic               modem_active_out,
  input wire logic               peer_active,
  input wire logic               lna_enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_modem_level: assert property ($past(rst_n) |-> modem_active_out == $past(tb.trx_on))
    else $error("modem level wrong");
  a_peer_sync: assert property ($past(rst_n, 3)
    |-> peer_active == ($past(peer_active_in, 3) && !$past(tb.pos_in_use)))
    else $error("peer level wrong");
  a_lna_route: assert property ($past(rst_n, 3)
    |-> lna_enable == ($past(peer_active_in, 3) && $past(tb.pos_in_use)))
    else $error("amplifier enable wrong");
  a_net_mark: assert property (!tb.pos_in_use && tb.net_tick |=> time_mark_out)
    else $error("network mark missing");
  a_pos_mark: assert property (tb.pos_in_use && tb.pos_tick |=> time_mark_out)
    else $error("positioning mark missing");
  // only network pulses are timed: a positioning tick may legally restart its pulse
  a_mark_width: assert property ($rose(time_mark_out) && !tb.pos_in_use
    |-> ##99 time_mark_out ##1 !time_mark_out) else $error("mark width wrong");
endmodule : rcs_chk
bind rcs_coex rcs_chk chk (.*);
`default_nettype wire

// file: rcs_peer.sv
// rcs_peer: companion radio that stays on whenever granted; assumes grant is active low
`timescale 1ns/100ps
`default_nettype none
module rcs_peer (
  input  wire logic modem_active_out,
  output var logic  peer_active_in
);
  initial peer_active_in = 1'b0;
  // skew keeps the peer pin off the clock edge, so the synchroniser sees a truly async level
  always @(modem_active_out) peer_active_in <= #3 !modem_active_out;
endmodule : rcs_peer
`default_nettype wire

// file: rcs_pkg.sv
// rcs_pkg: constants and carrier types for the radio coexistence signalling block
// assumes a 100 MHz system clock; no software-visible registers
package rcs_pkg;

  localparam int unsigned CLK_PERIOD_NS   = 10;
  // time-mark pulse width in ns and derived cycles
  localparam int unsigned MARK_WIDTH_NS   = 1000;
  localparam int unsigned MARK_WIDTH_CYC  = (MARK_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // once-per-second interval
  localparam int unsigned PPS_PERIOD_NS   = 1000000000;
  localparam int unsigned PPS_PERIOD_CYC  = PPS_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned SYNC_STAGES     = 2;
  localparam logic        RESET_LEVEL     = 1'h0;
  // counter values after reset
  localparam logic [31:0] PPS_CNT_RESET   = 32'h0;
  localparam logic [15:0] MARK_CNT_RESET  = 16'h0;

  typedef enum logic [0:0] {
    RCS_SRC_NETWORK = 1'h0,
    RCS_SRC_POS     = 1'h1
  } rcs_src_t;

  // timing inputs from the modem time base
  typedef struct packed {
    logic net_tick;
    logic pos_tick;
    logic pos_in_use;
    logic trx_on;
  } rcs_time_t;

endpackage : rcs_pkg

// file: rcs_sync.sv
// rcs_sync: two-flop synchroniser for one asynchronous level
// assumes the first flop feeds only the second
`timescale 1ns/100ps
`default_nettype none
module rcs_sync (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic d,
  output logic      q
);
  logic meta;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= 1'h0;
      q    <= 1'h0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule : rcs_sync
`default_nettype wire
